// ### core/fes_selector.sv
// Purpose: front-end event selection, qualification and counting
// Assumes: event inputs come from logic on the same clock
// Notes:   software writes to a counter win over an increment
`timescale 1ns/1ps

// Contract
// - Flushes count on code 06H with mask bit 4 only through trace-cache selectors on counters 4 to 7.
// - Code 013H with config select 06H accumulates not-stopped time on counters 0 to 3 only.
// - The running qualifier counts halt, stop-clock and throttling as active time.
// - Code 05H from the sequencer selectors counts switches of delivery from trace cache to sequencer ROM.
// - Mask bit 0 of the delivery-switch event counts each transfer once.
// - Code 09H counts valid micro-op queue writes of the source types enabled in the mask.
// - Queue-write mask bit 0 is build mode, bit 1 deliver mode, bit 2 microcode ROM.
// - Code 05H in bits 30 to 25 of the branch-unit selector counts retiring mispredicted branches.
// - Mispredict mask bit 1 takes conditional jumps and bit 2 indirect calls.
module fes_selector
    import fes_pkg::*;
#(
    parameter int CNT_W = DATA_W
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              arst_n,
    // register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [DATA_W-1:0] regRdata,
    // trace cache events
    input  wire logic              traceFlush,
    // power state levels
    input  wire logic              coreActive,
    input  wire logic              haltInstruction,
    input  wire logic              stopClockRequest,
    input  wire logic              throttleActive,
    // sequencer events
    input  wire logic              deliverySwitchEvent,
    input  wire logic              qwrBuildModeSource,
    input  wire logic              qwrDeliverModeSource,
    input  wire logic              qwrRomSource,
    // branch unit retirement events
    input  wire logic              mispredCondRetire,
    input  wire logic              mispredCallRetire
);

    if (CNT_W != DATA_W) begin : g_bad_width
        $error("fes_selector: CNT_W must equal DATA_W");
    end

    ////////////////////////////////////////////////////////////////////////
    // register storage

    logic [DATA_W-1:0] selReg_ff  [CNT_NUM];
    logic [DATA_W-1:0] cfgReg_ff  [CNT_NUM];
    logic [CNT_W-1:0]  cntView    [CNT_NUM];
    logic [DATA_W-1:0] regRdata_ff;
    logic [DATA_W-1:0] nxt_regRdata;
    logic [1:0]        regSpace;
    logic [2:0]        regEntry;

    assign regSpace = regAddr[4:3];
    assign regEntry = regAddr[2:0];

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < CNT_NUM; i++) begin
                selReg_ff[i] <= ES_RST;
            end
        end else if (regWr && regSpace == REG_SEL) begin
            selReg_ff[regEntry] <= regWdata & ES_WMASK;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < CNT_NUM; i++) begin
                cfgReg_ff[i] <= CC_RST;
            end
        end else if (regWr && regSpace == REG_CFG) begin
            cfgReg_ff[regEntry] <= regWdata & CC_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port: data stand only in the cycle after the strobe

    always_comb begin
        nxt_regRdata = '0;
        if (regRd) begin
            unique case (regSpace)
                REG_SEL:  nxt_regRdata = selReg_ff[regEntry];
                REG_CFG:  nxt_regRdata = cfgReg_ff[regEntry];
                REG_CNT:  nxt_regRdata = cntView[regEntry];
                default:  nxt_regRdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            regRdata_ff <= '0;
        end else begin
            regRdata_ff <= nxt_regRdata;
        end
    end

    assign regRdata = regRdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // shared event qualifiers

    logic running;

    // halted, stop-clock and throttled time still counts as active
    assign running = coreActive | haltInstruction | stopClockRequest | throttleActive;

    ////////////////////////////////////////////////////////////////////////
    // per-unit decode of one selection register into a step

    function automatic logic [1:0] traceStep(input logic [DATA_W-1:0] es);
        logic [15:0] m;
        m = es[ES_MASK_HI:ES_MASK_LO];
        traceStep = 2'h0;
        if (es[ES_CODE_HI:ES_CODE_LO] == EV_TRACE_MISC && m[MB_FLUSH] && traceFlush) begin
            traceStep = TRACE_STEP;
        end
    endfunction : traceStep

    function automatic logic [1:0] fsbStep(input logic [DATA_W-1:0] es);
        logic [15:0] m;
        m = es[ES_MASK_HI:ES_MASK_LO];
        fsbStep = 2'h0;
        // one count per cycle of not-stopped time
        if (es[ES_CODE_HI:ES_CODE_LO] == EV_POWER && m[MB_RUNNING] && running) begin
            fsbStep = 2'h1;
        end
    endfunction : fsbStep

    function automatic logic [1:0] seqStep(input logic [DATA_W-1:0] es);
        logic [15:0] m;
        logic [6:0]  code;
        m       = es[ES_MASK_HI:ES_MASK_LO];
        code    = es[ES_CODE_HI:ES_CODE_LO];
        seqStep = 2'h0;
        if (code == EV_XFER) begin
            // a transfer pulse counts once
            if (m[MB_SEQXFER] && deliverySwitchEvent) begin
                seqStep = 2'h1;
            end
        end else if (code == EV_QWRITE) begin
            seqStep = 2'(m[MB_BUILD] & qwrBuildModeSource)
                    + 2'(m[MB_DELIVER] & qwrDeliverModeSource)
                    + 2'(m[MB_ROM] & qwrRomSource);
        end
    endfunction : seqStep

    function automatic logic [1:0] tbpuStep(input logic [DATA_W-1:0] es);
        logic [15:0] m;
        m        = es[ES_MASK_HI:ES_MASK_LO];
        tbpuStep = 2'h0;
        // six-bit code field; bit 31 is not part of it here
        if (es[ES_CODE6_HI:ES_CODE_LO] == EV_MISPRED) begin
            tbpuStep = 2'(m[MB_COND] & mispredCondRetire)
                     + 2'(m[MB_CALL] & mispredCallRetire);
        end
    endfunction : tbpuStep

    ////////////////////////////////////////////////////////////////////////
    // counters

    for (genvar i = 0; i < CNT_NUM; i++) begin : g_cnt
        // counters 0,1 and 4,5 use selector 0 of a unit, 2,3 and 6,7 selector 1
        localparam logic [2:0] HALF = 3'((i >> 1) & 1);

        logic [CNT_W-1:0] count_ff;
        logic [1:0]       step;
        logic [2:0]       ccSel;
        logic             ccEn;

        assign ccSel = cfgReg_ff[i][CC_SEL_HI:CC_SEL_LO];
        assign ccEn  = cfgReg_ff[i][CC_EN_BIT];

        always_comb begin
            step = 2'h0;
            if (ccEn) begin
                if (i <= FSB_CNT_LAST) begin
                    if (ccSel == CS_FSB) begin
                        step = fsbStep(selReg_ff[SEL_FSB + HALF]);
                    end
                end else begin
                    if (ccSel == CS_TRACE) begin
                        step = traceStep(selReg_ff[SEL_TRACE + HALF]);
                    end else if (ccSel == CS_SEQ) begin
                        step = seqStep(selReg_ff[SEL_SEQ + HALF]);
                    end else if (ccSel == CS_TBPU) begin
                        step = tbpuStep(selReg_ff[SEL_TBPU + HALF]);
                    end
                end
            end
        end

        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                count_ff <= CNT_RST;
            end else if (regWr && regSpace == REG_CNT && regEntry == 3'(i)) begin
                count_ff <= regWdata;
            end else begin
                count_ff <= count_ff + CNT_W'(step);
            end
        end

        assign cntView[i] = count_ff;
    end

endmodule : fes_selector

// ### core/fes_pkg.sv
// Purpose: constants for the front-end event selector
// Assumes: one core clock, plain register port, word index addressing
// Notes:   index = addr; region in addr[4:3], entry in addr[2:0]
package fes_pkg;
    // register port geometry
    localparam int          ADDR_W        = 5;
    localparam int          DATA_W        = 32;
    localparam int          CNT_NUM       = 8;
    localparam logic [1:0]  REG_SEL       = 2'h0;
    localparam logic [1:0]  REG_CFG       = 2'h1;
    localparam logic [1:0]  REG_CNT       = 2'h2;

    // event selection register entries (index within region)
    localparam logic [2:0]  SEL_FSB       = 3'h0;
    localparam logic [2:0]  SEL_TRACE     = 3'h2;
    localparam logic [2:0]  SEL_SEQ       = 3'h4;
    localparam logic [2:0]  SEL_TBPU      = 3'h6;

    // event selection register fields
    localparam int          ES_CODE_HI    = 31;
    localparam int          ES_CODE6_HI   = 30;
    localparam int          ES_CODE_LO    = 25;
    localparam int          ES_MASK_HI    = 24;
    localparam int          ES_MASK_LO    = 9;

    // counter config register fields
    localparam int          CC_SEL_HI     = 15;
    localparam int          CC_SEL_LO     = 13;
    localparam int          CC_EN_BIT     = 12;

    // writable bits and reset values
    localparam logic [31:0] ES_WMASK      = 32'hffff_fe00;
    localparam logic [31:0] CC_WMASK      = 32'h0000_f000;
    localparam logic [31:0] ES_RST        = 32'h0000_0000;
    localparam logic [31:0] CC_RST        = 32'h0000_0000;
    localparam logic [31:0] CNT_RST       = 32'h0000_0000;

    // event codes
    localparam logic [6:0]  EV_TRACE_MISC = 7'h06;
    localparam logic [6:0]  EV_POWER      = 7'h13;
    localparam logic [6:0]  EV_XFER       = 7'h05;
    localparam logic [6:0]  EV_QWRITE     = 7'h09;
    localparam logic [5:0]  EV_MISPRED    = 6'h05;

    // counter config selects per unit
    localparam logic [2:0]  CS_TRACE      = 3'h1;
    localparam logic [2:0]  CS_FSB        = 3'h6;
    localparam logic [2:0]  CS_SEQ        = 3'h0;
    localparam logic [2:0]  CS_TBPU       = 3'h2;

    // mask bit positions within the 16-bit mask
    localparam int          MB_FLUSH      = 4;
    localparam int          MB_RUNNING    = 0;
    localparam int          MB_SEQXFER    = 0;
    localparam int          MB_BUILD      = 0;
    localparam int          MB_DELIVER    = 1;
    localparam int          MB_ROM        = 2;
    localparam int          MB_COND       = 1;
    localparam int          MB_CALL       = 2;

    // weight of one flush occurrence
    localparam logic [1:0]  TRACE_STEP    = 2'h2;

    // counters 0..3 sit behind the bus unit, 4..7 behind the others
    localparam int          FSB_CNT_LAST  = 3;
endpackage : fes_pkg

// ### tb/fes_event_source.sv
// Purpose: random source of front-end event inputs
// Assumes: outputs change just after the rising edge
// Notes:   all outputs stay low while go is low
`timescale 1ns/1ps
module fes_event_source (
    // control
    input  wire logic        clock,
    input  wire logic        go,
    // events: flush, four power levels, switch, three queue sources, two branch kinds
    output logic      [10:0] ev
);
    initial ev = 11'h0;
    always @(posedge clock) ev <= go ? 11'($urandom) : 11'h0;
endmodule : fes_event_source

// ### tb/fes_selector_asserts.sv
// Purpose: port-level checks of the event selector register port
// Assumes: bound onto every fes_selector instance
// Notes:   event counting itself is judged by the bench
`timescale 1ns/1ps
module fes_selector_asserts
    import fes_pkg::*;
#(
    parameter int CNT_W = DATA_W
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              arst_n,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic              regWr,
    input wire logic              regRd,
    input wire logic [DATA_W-1:0] regRdata,
    // event inputs
    input wire logic              traceFlush,
    input wire logic              coreActive,
    input wire logic              haltInstruction,
    input wire logic              stopClockRequest,
    input wire logic              throttleActive,
    input wire logic              deliverySwitchEvent,
    input wire logic              qwrBuildModeSource,
    input wire logic              qwrDeliverModeSource,
    input wire logic              qwrRomSource,
    input wire logic              mispredCondRetire,
    input wire logic              mispredCallRetire
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    wire quiet = !(traceFlush | coreActive | haltInstruction | stopClockRequest | throttleActive
        | deliverySwitchEvent | qwrBuildModeSource | qwrDeliverModeSource | qwrRomSource | mispredCondRetire
        | mispredCallRetire);
    ////////////////////////////////////////
    sequence cfgWrRd;
        regWr && regAddr[4:3] == REG_CFG ##1 !regWr ##1 regRd && regAddr == $past(regAddr, 2);
    endsequence
    sequence selWrRd;
        regWr && regAddr[4:3] == REG_SEL ##1 !regWr ##1 regRd && regAddr == $past(regAddr, 2);
    endsequence
    sequence cntRdRd;
        regRd && regAddr[4:3] == REG_CNT && quiet ##1 regRd && regAddr == $past(regAddr) && quiet;
    endsequence
    a_rdata_idle_zero: assert property (!$past(regRd) |-> regRdata == '0) else $error("idle read data not zero");
    a_unmapped_read_zero: assert property (regRd && regAddr[4:3] == 2'h3 |=> regRdata == '0)
        else $error("unmapped read not zero");
    a_sel_low_zero: assert property (regRd && regAddr[4:3] == REG_SEL |=> regRdata[8:0] == 9'h0)
        else $error("selector low bits not zero");
    a_cfg_bits_zero: assert property (regRd && regAddr[4:3] == REG_CFG |=> (regRdata & ~CC_WMASK) == '0)
        else $error("config spare bits not zero");
    a_cfg_write_read: assert property (cfgWrRd |=> regRdata == ($past(regWdata, 3) & CC_WMASK))
        else $error("config readback wrong");
    a_sel_write_read: assert property (selWrRd |=> regRdata == ($past(regWdata, 3) & ES_WMASK))
        else $error("selector readback wrong");
    a_counter_holds: assert property (cntRdRd |=> regRdata == $past(regRdata))
        else $error("counter moved without events");
    a_reset_clear: assert property ($rose(arst_n) |-> regRdata == '0) else $error("read data not clear after reset");
endmodule : fes_selector_asserts
bind fes_selector fes_selector_asserts #(.CNT_W(CNT_W)) u_chk (.clock(clock), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .traceFlush(traceFlush),
    .coreActive(coreActive), .haltInstruction(haltInstruction), .stopClockRequest(stopClockRequest),
    .throttleActive(throttleActive), .deliverySwitchEvent(deliverySwitchEvent),
    .qwrBuildModeSource(qwrBuildModeSource), .qwrDeliverModeSource(qwrDeliverModeSource),
    .qwrRomSource(qwrRomSource), .mispredCondRetire(mispredCondRetire), .mispredCallRetire(mispredCallRetire));

// ### tb/test_fes_selector.sv
// Purpose: self-checking bench for the front-end event selector
// Assumes: register port answers one cycle after the read strobe
// Notes:   expected counts are tallied from the sampled event inputs
`timescale 1ns/1ps
module test_fes_selector;
    import fes_pkg::*;
    logic              clock = 1'b0;
    logic              arst_n = 1'b0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWdata = '0;
    logic              regWr = 1'b0;
    logic              regRd = 1'b0;
    logic [DATA_W-1:0] regRdata;
    logic              go = 1'b0;
    logic [10:0]       ev;
    logic [31:0]       w;
    int                numErrors = 0;
    int                checksDone = 0;
    int                nRun;
    int                n [11];
    fes_event_source src (.clock(clock), .go(go), .ev(ev));
    fes_selector uut (.clock(clock), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .traceFlush(ev[0]), .coreActive(ev[1]), .haltInstruction(ev[2]),
        .stopClockRequest(ev[3]), .throttleActive(ev[4]), .deliverySwitchEvent(ev[5]),
        .qwrBuildModeSource(ev[6]), .qwrDeliverModeSource(ev[7]), .qwrRomSource(ev[8]),
        .mispredCondRetire(ev[9]), .mispredCallRetire(ev[10]));
    ////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d, errors %0d", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            numErrors++;
            $display("Error at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask : wr
    // two back-to-back reads of one address
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        @(posedge clock);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clock);
        @(posedge clock);
        regRd <= 1'b0;
        chk(regRdata, e);
        @(posedge clock);
        chk(regRdata, e);
    endtask : rd
    function automatic logic [31:0] expect_count(input int k);
        case (k)
            0: return 32'(2 * n[0]);
            1: return 32'(nRun);
            2: return 32'(n[5]);
            3: return 32'(n[6] + n[8]);
            4: return 32'(n[9] + n[10]);
            6: return 32'(n[9]);
            7: return 32'(n[7]);
            default: return 32'h0;
        endcase
    endfunction : expect_count
    task automatic scen(input int c, input int s, input logic [6:0] code, input logic [15:0] m,
                        input logic [2:0] cs, input int k);
        wr(5'(s), {code, m, 9'h0});
        wr(5'(8 + c), {16'h0, cs, 13'h1000});
        wr(5'(16 + c), 32'h0);
        n = '{default: 0};
        nRun = 0;
        go <= 1'b1;
        for (int i = 0; i < 43; i++) begin
            @(posedge clock);
            if (i == 40) go <= 1'b0;
            foreach (n[j]) n[j] += int'(ev[j]);
            nRun += int'(|ev[4:1]);
        end
        rd(5'(16 + c), expect_count(k));
    endtask : scen
    initial forever #5 clock = ~clock;
    initial begin
        repeat (20000) @(posedge clock);
        numErrors++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h44cf));
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        for (int a = 0; a < 32; a++) rd(5'(a), 32'h0);
        w = $urandom();
        wr(5'h01, w);
        rd(5'h01, w & ES_WMASK);
        wr(5'h0a, w);
        rd(5'h0a, w & CC_WMASK);
        wr(5'h17, w);
        rd(5'h17, w);
        wr(5'h18, w);
        rd(5'h18, 32'h0);
        scen(4, 2, EV_TRACE_MISC, 16'h0010, CS_TRACE, 0);
        scen(6, 3, EV_TRACE_MISC, 16'h0010, CS_TRACE, 0);
        scen(0, 0, EV_POWER, 16'h0001, CS_FSB, 1);
        scen(3, 1, EV_POWER, 16'h0001, CS_FSB, 1);
        scen(6, 5, EV_XFER, 16'h0001, CS_SEQ, 2);
        scen(4, 4, EV_QWRITE, 16'h0005, CS_SEQ, 3);
        scen(5, 4, EV_QWRITE, 16'h0002, CS_SEQ, 7);
        scen(6, 7, {1'b1, EV_MISPRED}, 16'h0006, CS_TBPU, 4);
        scen(4, 6, {1'b0, EV_MISPRED}, 16'h0002, CS_TBPU, 6);
        scen(4, 2, EV_TRACE_MISC, 16'h0010, CS_FSB, 5);
        scen(0, 0, EV_TRACE_MISC, 16'h0010, CS_TRACE, 5);
        scen(4, 2, EV_TRACE_MISC, 16'h0008, CS_TRACE, 5);
        give_verdict();
    end
endmodule : test_fes_selector
